// ---- core/tws_slave.v ----
// two-wire slave engine with classic wishbone register slave
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.vh"

module tws_slave (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        scl_i,
    output reg         scl_oe_n,
    input  wire        sda_i,
    output reg         sda_oe_n
);
    // ****************************************************************
    // states
    // ****************************************************************
    localparam [2:0] ST_IDLE = 3'd0, ST_ADDR = 3'd1, ST_AACK = 3'd2, ST_RX = 3'd3;
    localparam [2:0] ST_RACK = 3'd4, ST_TX = 3'd5, ST_TACK = 3'd6, ST_SKIP = 3'd7;

    wire       scl_s;
    wire       sda_s;
    reg        scl_d_reg, sda_d_reg;
    reg  [2:0] state_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    reg  [7:0] rx_hold_reg;
    reg  [7:0] tx_hold_reg;
    reg        tx_full_reg;
    reg        shift_loaded_reg;
    reg        pend_rx_reg;
    reg  [6:0] own_bus_address;
    reg [31:0] clock_waveform_reg;
    reg        slave_en_reg, master_en_reg;
    reg        slave_access_flag, slave_direction_flag, end_of_access_flag;
    reg        transmission_complete_flag, receive_ready_flag, nack_flag;
    reg        general_call_access_flag;
    reg        soft_rst_reg;

    tws_sync u_sync_scl (.clk(clk), .reset_n(reset_n), .din(scl_i), .dout(scl_s));
    tws_sync u_sync_sda (.clk(clk), .reset_n(reset_n), .din(sda_i), .dout(sda_s));

    // ****************************************************************
    // bus condition detection
    // ****************************************************************
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire active   = slave_en_reg & ~master_en_reg;
    wire [7:0] addr_byte = {shift_reg[6:0], sda_s};
    wire addr_match = (addr_byte[7:1] == own_bus_address);
    wire gen_call   = (addr_byte == 8'h00);

    // ****************************************************************
    // register bus decode
    // ****************************************************************
    wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_req   = bus_req & wb_we_i & wb_sel_i[0];
    wire wr_ctrl  = wr_req & (wb_adr_i == `TWS_CONTROL_REG_OFF);
    wire wr_addr  = bus_req & wb_we_i & wb_sel_i[2] & (wb_adr_i == `TWS_SLAVE_MODE_REG_OFF);
    wire wr_cwg   = bus_req & wb_we_i & (wb_adr_i == `TWS_CLOCK_WAVEFORM_OFF);
    wire wr_tx    = wr_req & (wb_adr_i == `TWS_TRANSMIT_HOLDING_OFF);
    wire rd_rx    = bus_req & ~wb_we_i & (wb_adr_i == `TWS_RECEIVE_HOLDING_OFF);
    wire cmd_slave_enable_cmd = wr_ctrl & wb_dat_i[`TWS_CMD_SLAVE_ENABLE];
    wire cmd_svds = wr_ctrl & wb_dat_i[`TWS_CMD_SLAVE_DISABLE];
    wire cmd_msen = wr_ctrl & wb_dat_i[`TWS_CMD_MASTER_ENABLE];
    wire cmd_msds = wr_ctrl & wb_dat_i[`TWS_CMD_MASTER_DISABLE];
    wire cmd_rst  = wr_ctrl & wb_dat_i[`TWS_CMD_SOFT_RESET];

    // stretch conditions; the scl line is only held after it is already low
    wire tx_phase = (state_reg == ST_TX) | (state_reg == ST_AACK & slave_direction_flag);
    wire stretch_rd = active & slave_access_flag & slave_direction_flag & tx_phase
                      & ~shift_loaded_reg & ~tx_full_reg & ~scl_s;
    wire stretch_wr = active & pend_rx_reg & receive_ready_flag & ~scl_s;
    wire stretch    = stretch_rd | stretch_wr;
    wire tx_ready   = ~tx_full_reg & ~shift_loaded_reg; // no dma request

    // status word, read side shows engine state
    wire [31:0] status_word = {20'h0_0000, end_of_access_flag, stretch, 1'b0, nack_flag,
                               2'b00, general_call_access_flag, slave_access_flag,
                               slave_direction_flag & slave_access_flag,
                               tx_ready, receive_ready_flag, transmission_complete_flag};

    // ****************************************************************
    // wishbone answer: one cycle after the request, then dropped
    // ****************************************************************
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req & ~wb_we_i) begin
                if (wb_adr_i == `TWS_SLAVE_MODE_REG_OFF)
                    wb_dat_o <= {9'h000, own_bus_address, 16'h0000};
                else if (wb_adr_i == `TWS_CLOCK_WAVEFORM_OFF)
                    wb_dat_o <= clock_waveform_reg;
                else if (wb_adr_i == `TWS_STATUS_REG_OFF)
                    wb_dat_o <= status_word;
                else if (wb_adr_i == `TWS_RECEIVE_HOLDING_OFF)
                    wb_dat_o <= {24'h00_0000, rx_hold_reg};
                else
                    wb_dat_o <= 32'h0000_0000; // unmapped reads zero
            end
        end
    end

    // ****************************************************************
    // configuration and mode
    // ****************************************************************
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            own_bus_address    <= `TWS_ADDR_RESET;
            clock_waveform_reg <= `TWS_CWG_RESET;
            slave_en_reg       <= 1'b0;
            master_en_reg      <= 1'b0;
            soft_rst_reg       <= 1'b0;
        end else if (soft_rst_reg) begin
            own_bus_address    <= `TWS_ADDR_RESET;
            clock_waveform_reg <= `TWS_CWG_RESET;
            slave_en_reg       <= 1'b0;
            master_en_reg      <= 1'b0;
            soft_rst_reg       <= 1'b0;
        end else begin
            soft_rst_reg <= cmd_rst;
            if (wr_addr & (~slave_en_reg | general_call_access_flag))
                own_bus_address <= wb_dat_i[`TWS_ADDR_MSB:`TWS_ADDR_LSB];
            if (wr_cwg)
                clock_waveform_reg <= wb_dat_i; // stored only, never drives timing
            if (cmd_svds)
                slave_en_reg <= 1'b0;
            else if (cmd_slave_enable_cmd & transmission_complete_flag)
                slave_en_reg <= 1'b1;
            if (cmd_msds)
                master_en_reg <= 1'b0;
            else if (cmd_msen & transmission_complete_flag)
                master_en_reg <= 1'b1; // master engine itself is not present
        end
    end

    // ****************************************************************
    // bus engine
    // ****************************************************************
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rx_hold_reg <= 8'h00;
            tx_hold_reg <= 8'h00;
            tx_full_reg <= 1'b0;
            shift_loaded_reg <= 1'b0;
            pend_rx_reg <= 1'b0;
            slave_access_flag <= 1'b0;
            slave_direction_flag <= 1'b0;
            end_of_access_flag <= 1'b0;
            transmission_complete_flag <= 1'b1;
            receive_ready_flag <= 1'b0;
            nack_flag <= 1'b0;
            general_call_access_flag <= 1'b0;
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
        end else if (soft_rst_reg) begin
            state_reg <= ST_IDLE;
            tx_full_reg <= 1'b0;
            shift_loaded_reg <= 1'b0;
            pend_rx_reg <= 1'b0;
            slave_access_flag <= 1'b0;
            end_of_access_flag <= 1'b0;
            transmission_complete_flag <= 1'b1;
            receive_ready_flag <= 1'b0;
            nack_flag <= 1'b0;
            general_call_access_flag <= 1'b0;
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            scl_oe_n  <= ~stretch;
            // status read clears the sticky event flags; a new event wins
            if (bus_req & ~wb_we_i & (wb_adr_i == `TWS_STATUS_REG_OFF)) begin
                end_of_access_flag <= 1'b0;
                nack_flag <= 1'b0;
            end
            if (wr_tx & ~tx_full_reg) begin
                tx_hold_reg <= wb_dat_i[7:0];
                tx_full_reg <= 1'b1;
            end
            if (rd_rx)
                receive_ready_flag <= 1'b0;
            // parked byte moves into holding once software drained it
            if (pend_rx_reg & (~receive_ready_flag | rd_rx)) begin
                rx_hold_reg <= shift_reg;
                receive_ready_flag <= 1'b1;
                pend_rx_reg <= 1'b0;
            end
            if (!active) begin
                state_reg <= ST_IDLE;
                sda_oe_n <= 1'b1;
            end else if (start_c | stop_c) begin
                // conditions only observed, never generated
                if (slave_access_flag)
                    end_of_access_flag <= 1'b1;
                if (stop_c) begin
                    if (slave_access_flag)
                        transmission_complete_flag <= 1'b1;
                    slave_access_flag <= 1'b0;
                    general_call_access_flag <= 1'b0;
                    state_reg <= ST_IDLE;
                end else begin
                    state_reg <= ST_ADDR;
                end
                shift_loaded_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
                sda_oe_n <= 1'b1;
            end else begin
                case (state_reg)
                ST_ADDR: if (scl_rise) begin
                    shift_reg <= addr_byte;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'h7) begin
                        if (addr_match | gen_call) begin
                            state_reg <= ST_AACK;
                            slave_access_flag <= 1'b1;
                            slave_direction_flag <= sda_s;
                            transmission_complete_flag <= 1'b0;
                            general_call_access_flag <= gen_call;
                        end else begin
                            if (slave_access_flag)
                                transmission_complete_flag <= 1'b1;
                            slave_access_flag <= 1'b0;
                            state_reg <= ST_SKIP;
                        end
                    end
                end
                ST_AACK, ST_RACK: begin
                    if (scl_fall & sda_oe_n) begin
                        sda_oe_n <= 1'b0; // drive ack low
                    end else if (scl_fall & ~sda_oe_n) begin
                        sda_oe_n <= 1'b1;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= slave_direction_flag ? ST_TX : ST_RX;
                    end
                end
                ST_RX: if (scl_rise) begin
                    shift_reg <= addr_byte;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'h7) begin
                        pend_rx_reg <= 1'b1;
                        state_reg <= ST_RACK;
                    end
                end
                ST_TX: begin
                    if (~shift_loaded_reg & tx_full_reg & ~scl_s) begin
                        shift_reg <= tx_hold_reg;
                        shift_loaded_reg <= 1'b1;
                        tx_full_reg <= 1'b0; // a racing write is refused
                        sda_oe_n <= tx_hold_reg[7];
                    end else if (shift_loaded_reg & scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'h7) begin
                            sda_oe_n <= 1'b1; // release for master ack
                            state_reg <= ST_TACK;
                        end else begin
                            sda_oe_n <= shift_reg[6];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                    end
                end
                ST_TACK: if (scl_rise) begin
                    shift_loaded_reg <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    if (sda_s) begin
                        nack_flag <= 1'b1;
                        state_reg <= ST_SKIP;
                    end else begin
                        state_reg <= ST_TX;
                    end
                end
                default: sda_oe_n <= 1'b1; // idle and skip stay released
                endcase
            end
        end
    end
endmodule // tws_slave

`default_nettype wire

// ---- core/tws_regs.vh ----
// register offsets, field positions and reset values of the two-wire slave
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define TWS_CONTROL_REG_OFF      8'h00
`define TWS_SLAVE_MODE_REG_OFF   8'h08
`define TWS_CLOCK_WAVEFORM_OFF   8'h10
`define TWS_STATUS_REG_OFF       8'h20
`define TWS_RECEIVE_HOLDING_OFF  8'h30
`define TWS_TRANSMIT_HOLDING_OFF 8'h34

// ****************************************************************
// control command bits
// ****************************************************************
`define TWS_CMD_MASTER_ENABLE    2
`define TWS_CMD_MASTER_DISABLE   3
`define TWS_CMD_SLAVE_ENABLE     4
`define TWS_CMD_SLAVE_DISABLE    5
`define TWS_CMD_SOFT_RESET       7

// ****************************************************************
// slave mode field and status bits
// ****************************************************************
`define TWS_ADDR_LSB             16
`define TWS_ADDR_MSB             22
`define TWS_ST_COMPLETE          0
`define TWS_ST_RX_READY          1
`define TWS_ST_TX_READY          2
`define TWS_ST_DIRECTION         3
`define TWS_ST_ACCESS            4
`define TWS_ST_GENERAL_CALL      5
`define TWS_ST_NACK              8
`define TWS_ST_WAIT_STATE        10
`define TWS_ST_END_ACCESS        11

// ****************************************************************
// reset values
// ****************************************************************
`define TWS_ADDR_RESET           7'h00
`define TWS_CWG_RESET            32'h0000_0000

`endif

// ---- core/tws_sync.v ----
// two flip-flop synchroniser for one bus pin
`timescale 1ns/1ns
`default_nettype none

module tws_sync (
    input  wire clk,
    input  wire reset_n,
    input  wire din,
    output reg  dout
);
    reg meta_reg;

    // resets high: an idle bus line floats high
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 1'b1;
            dout     <= 1'b1;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule // tws_sync

`default_nettype wire

// ---- sim/tws_slave_properties.sv ----
// concurrent checks on the ports of the two-wire slave engine
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.vh"
module tws_slave_props (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        scl_i,
    input wire logic        scl_oe_n,
    input wire logic        sda_i,
    input wire logic        sda_oe_n
);
    // ****************************************************************
    // bus answer, wire discipline and status coherence
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // read answers; address is still held by the master at the ack edge
    wire rd_ack = wb_ack_o && !wb_we_i;
    wire st_rd  = rd_ack && (wb_adr_i == `TWS_STATUS_REG_OFF);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    chk_unmapped_zero: assert property (rd_ack && wb_adr_i > 8'h34 |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read returned data");
    // sda only moves with scl low, so the slave can never form start or stop
    chk_sda_quiet: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n))
        else $error("slave moved sda while scl was high");
    chk_stretch_low: assert property ($fell(scl_oe_n) |-> !scl_i && !$past(scl_i))
        else $error("stretch began while scl was high");
    // two quiet cycles allow the pin driver to trail the flag by one register
    chk_wait_flag: assert property (
        st_rd && $stable(scl_oe_n) && $past(scl_oe_n, 2) == scl_oe_n
        |-> wb_dat_o[`TWS_ST_WAIT_STATE] == !scl_oe_n)
        else $error("wait state flag disagrees with stretch");
    chk_dir_idle: assert property (
        st_rd && !wb_dat_o[`TWS_ST_ACCESS] |-> !wb_dat_o[`TWS_ST_DIRECTION])
        else $error("direction set without access");
    cov_stretch: cover property ($fell(scl_oe_n));
    cov_slave_drive: cover property ($fell(sda_oe_n));
    cov_general_call: cover property (st_rd && wb_dat_o[`TWS_ST_GENERAL_CALL]);
endmodule // tws_slave_props
bind tws_slave tws_slave_props i_props (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i),
    .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_oe_n(sda_oe_n));
`default_nettype wire

// ---- sim/tws_master_model.sv ----
// two-wire bus master model that drives the slave from the far side
`timescale 1ns/1ns
`default_nettype none
module tws_master_model #(
    parameter int HALF = 20
) (
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output var  logic scl_oe_n,
    output var  logic sda_oe_n,
    output var  logic stretching,
    output var  logic timed_out
);
    // ****************************************************************
    // bus conditions and bits, every change just after a clock edge
    // ****************************************************************
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
        stretching = 1'b0;
        timed_out = 1'b0;
    end
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask
    // let scl go and wait out a stretch; bounded so a stuck slave ends the run
    task automatic rise_scl();
        int n;
        n = 0;
        scl_oe_n <= 1'b1;
        @(posedge clk);
        while (scl !== 1'b1 && n < 5000) begin
            n++;
            stretching <= (n > 4);
            @(posedge clk);
        end
        stretching <= 1'b0;
        timed_out <= (n >= 5000);
    endtask
    // also serves as repeated start when entered with scl low
    task automatic start_cond();
        sda_oe_n <= 1'b1;
        pause(HALF);
        rise_scl();
        pause(HALF);
        sda_oe_n <= 1'b0;
        pause(HALF);
        scl_oe_n <= 1'b0;
        pause(HALF);
    endtask
    task automatic stop_cond();
        sda_oe_n <= 1'b0;
        pause(HALF);
        rise_scl();
        pause(HALF);
        sda_oe_n <= 1'b1;
        pause(2 * HALF);
    endtask
    // data moves only a few cycles after scl falls, never in the same cycle
    task automatic put_bit(input logic b);
        sda_oe_n <= b;
        pause(HALF);
        rise_scl();
        pause(HALF);
        scl_oe_n <= 1'b0;
        pause(4);
    endtask
    task automatic get_bit(output logic b);
        sda_oe_n <= 1'b1;
        pause(HALF);
        rise_scl();
        pause(HALF / 2);
        b = sda;
        pause(HALF / 2);
        scl_oe_n <= 1'b0;
        pause(4);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic acked);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        acked = !b;
    endtask
    task automatic take_byte(input logic give_ack, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(!give_ack);
    endtask
endmodule // tws_master_model
`default_nettype wire

// ---- sim/tws_slave_tb.sv ----
// self-checking bench for the two-wire slave engine
`timescale 1ns/1ns
`default_nettype none
`include "tws_regs.vh"
module tws_slave_tb;
    logic        clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        scl_oe_n, sda_oe_n, m_scl_oe_n, m_sda_oe_n, stretching, m_timeout;
    int          fail_count, checks;
    wire         scl_w = scl_oe_n & m_scl_oe_n;
    wire         sda_w = sda_oe_n & m_sda_oe_n;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] BIT = 32'h0000_0001;
    localparam logic [31:0] CMP = BIT << `TWS_ST_COMPLETE;
    localparam logic [31:0] RXR = BIT << `TWS_ST_RX_READY;
    localparam logic [31:0] TXR = BIT << `TWS_ST_TX_READY;
    localparam logic [31:0] DIR = BIT << `TWS_ST_DIRECTION;
    localparam logic [31:0] ACC = BIT << `TWS_ST_ACCESS;
    localparam logic [31:0] GCA = BIT << `TWS_ST_GENERAL_CALL;
    localparam logic [31:0] NAK = BIT << `TWS_ST_NACK;
    localparam logic [31:0] WST = BIT << `TWS_ST_WAIT_STATE;
    localparam logic [31:0] EOA = BIT << `TWS_ST_END_ACCESS;
    localparam logic [7:0]  STA = `TWS_STATUS_REG_OFF;
    localparam logic [7:0]  SMR = `TWS_SLAVE_MODE_REG_OFF;
    localparam logic [7:0]  RHR = `TWS_RECEIVE_HOLDING_OFF;
    localparam logic [7:0]  THR = `TWS_TRANSMIT_HOLDING_OFF;
    localparam logic [7:0]  CTL = `TWS_CONTROL_REG_OFF;
    tws_slave i_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w), .scl_oe_n(scl_oe_n),
        .sda_i(sda_w), .sda_oe_n(sda_oe_n));
    tws_master_model i_mst (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_oe_n(m_scl_oe_n),
        .sda_oe_n(m_sda_oe_n), .stretching(stretching), .timed_out(m_timeout));
    // ****************************************************************
    // access tasks and comparison
    // ****************************************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; waits for ack, never assumes the latency
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                           output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        @(posedge clk);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
        if (n >= 50) fail_count++;
        if (n >= 50) report_and_stop();
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, adr, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 32'h0000_0000, q);
        check(q & m, e);
    endtask
    task automatic send(input logic [7:0] b, input logic e);
        logic ak;
        i_mst.send_byte(b, ak);
        check(32'(ak), 32'(e));
    endtask
    task automatic open(input logic [7:0] b, input logic e);
        i_mst.start_cond();
        send(b, e);
    endtask
    task automatic take(input logic give, input logic [7:0] e);
        logic [7:0] d;
        i_mst.take_byte(give, d);
        check(32'(d), 32'(e));
    endtask
    // waits for a fresh stretch episode, so a fading one is not counted twice
    task automatic wait_stretch();
        int n;
        n = 0;
        while (stretching === 1'b1 && n < 4000) begin
            n++;
            @(posedge clk);
        end
        while (stretching !== 1'b1 && n < 4000) begin
            n++;
            @(posedge clk);
        end
        if (n >= 4000) fail_count++;
        if (n >= 4000) report_and_stop();
    endtask
    // ****************************************************************
    // clock, watchdogs and the scenario sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (m_timeout === 1'b1) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (80000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        fail_count = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd_chk(STA, CMP | ACC, CMP);
        rd_chk(8'h40, ALL, 32'h0000_0000);
        wr(`TWS_CLOCK_WAVEFORM_OFF, ALL);
        open(8'h54, 1'b0);
        i_mst.stop_cond();
        wr(SMR, 32'h002A_0000);
        wr(CTL, 32'h0000_0018);
        wr(SMR, 32'h0011_0000);
        rd_chk(SMR, ALL, 32'h002A_0000);
        open(8'h22, 1'b0);
        i_mst.stop_cond();
        // master write, software slow so the clock is held twice
        open(8'h54, 1'b1);
        rd_chk(STA, ACC | DIR, ACC);
        send(8'hA5, 1'b1);
        rd_chk(STA, RXR, RXR);
        fork
            begin
                send(8'h3C, 1'b1);
                send(8'h77, 1'b1);
                i_mst.stop_cond();
            end
            begin
                wait_stretch();
                rd_chk(STA, WST, WST);
                rd_chk(RHR, ALL, 32'h0000_00A5);
                wait_stretch();
                rd_chk(RHR, ALL, 32'h0000_003C);
            end
        join
        rd_chk(RHR, ALL, 32'h0000_0077);
        rd_chk(STA, CMP | ACC | EOA | RXR | WST, CMP | EOA);
        // write then read on one transaction, holding register empty at reversal
        open(8'h54, 1'b1);
        send(8'h10, 1'b1);
        fork
            open(8'h55, 1'b1);
            begin
                wait_stretch();
                rd_chk(STA, WST | CMP, WST);
                wr(THR, 32'h0000_00C3);
            end
        join
        rd_chk(STA, ACC | DIR, ACC | DIR);
        wr(THR, 32'h0000_005A);
        rd_chk(STA, TXR, 32'h0000_0000);
        take(1'b1, 8'hC3);
        take(1'b0, 8'h5A);
        rd_chk(STA, NAK | TXR, NAK | TXR);
        i_mst.stop_cond();
        rd_chk(STA, CMP | ACC, CMP);
        rd_chk(RHR, ALL, 32'h0000_0010);
        // general call then a new own address
        open(8'h00, 1'b1);
        rd_chk(STA, GCA, GCA);
        wr(SMR, 32'h0033_0000);
        i_mst.stop_cond();
        rd_chk(SMR, ALL, 32'h0033_0000);
        open(8'h66, 1'b1);
        i_mst.stop_cond();
        wr(CTL, 32'h0000_0030);
        wr(SMR, 32'h0011_0000);
        rd_chk(SMR, ALL, 32'h0011_0000);
        wr(CTL, 32'h0000_0080);
        rd_chk(SMR, ALL, 32'h0000_0000);
        report_and_stop();
    end
endmodule // tws_slave_tb
`default_nettype wire
